/* File: sac_pkg.sv */
package sac_pkg;
    // register byte offsets
    localparam logic [11:0] SAC_OFS_CTRL = 12'h000;
    localparam logic [11:0] SAC_OFS_CHAN = 12'h004;
    localparam logic [11:0] SAC_OFS_RESULT = 12'h008;
    localparam logic [11:0] SAC_OFS_STATUS = 12'h00C;
    localparam logic [11:0] SAC_OFS_DAC = 12'h010;
    // reset values
    localparam logic [15:0] SAC_CTRL_RST = 16'h0600;
    localparam logic [4:0] SAC_CHAN_RST = 5'h00;
    localparam logic [11:0] SAC_DAC_RST = 12'h000;
    // control word field positions
    localparam int SAC_CTRL_CLK_LSB = 10;
    localparam int SAC_CTRL_ACQ_LSB = 8;
    localparam int SAC_CTRL_START_EN = 7;
    localparam int SAC_CTRL_BUSY_EN = 6;
    localparam int SAC_CTRL_POWER = 5;
    localparam int SAC_CTRL_MODE_LSB = 3;
    localparam int SAC_CTRL_TYPE_LSB = 0;
    // control word writable bits (15:13 reserved, read as zero)
    localparam logic [15:0] SAC_CTRL_MASK = 16'h1FFF;
    // result word field positions
    localparam int SAC_RES_LSB = 16;
    localparam int SAC_RES_MSB = 27;
    localparam int SAC_SIGN_LSB = 28;
    // status bits
    localparam int SAC_STAT_READY = 0;
    localparam int SAC_STAT_BUSY = 1;
    // internal temperature channel code
    localparam logic [4:0] SAC_CHAN_TEMP = 5'h10;
    // divider code above this saturates
    localparam logic [2:0] SAC_CLK_MAX = 3'h5;
    // input configurations
    typedef enum logic [1:0] {
        SAC_MODE_SINGLE = 2'h0,
        SAC_MODE_DIFF = 2'h1,
        SAC_MODE_PSEUDO = 2'h2
    } sac_mode_type;
    // conversion start sources
    typedef enum logic [2:0] {
        SAC_TRIG_NONE = 3'h0,
        SAC_TRIG_PIN = 3'h1,
        SAC_TRIG_TMR0 = 3'h2,
        SAC_TRIG_TMR1 = 3'h3,
        SAC_TRIG_SINGLE = 3'h4,
        SAC_TRIG_CONT = 3'h5,
        SAC_TRIG_PLA = 3'h6
    } sac_trig_type;
endpackage

/* File: sac_stream_if.sv */
`timescale 1ns/1ps
interface sac_stream_if #(
    parameter int W = 32
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

/* File: sac_buf2.sv */
`timescale 1ns/1ps
module sac_buf2 #(
    parameter int W = 32,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // filling and draining sides
    sac_stream_if.snk in_s,
    sac_stream_if.src out_s
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH); // full when every entry holds a word

    logic [W-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    wire push = in_s.valid && in_s.ready;
    wire pop = out_s.valid && out_s.ready;

    // handshake flags
    assign in_s.ready = (count_reg != FULL_CNT);
    assign out_s.valid = (count_reg != '0);
    assign out_s.data = mem_reg[rd_ptr_reg];

    // one storage word per entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mem_reg[i] <= '0;
            end else if (push && wr_ptr_reg == PW'(i)) begin
                mem_reg[i] <= in_s.data;
            end
        end
    end

    // pointers and fill level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + PW'(1);
            if (pop) rd_ptr_reg <= rd_ptr_reg + PW'(1);
            count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

/* File: sac_ctrl.sv */
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module sac_ctrl import sac_pkg::*; #(
    parameter int PAW = 12
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [PAW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // conversion triggers
    input wire logic external_conversion_start_pin_n,
    input wire logic programmable_logic_array_trig,
    input wire logic timer0_ovf,
    input wire logic timer1_ovf,
    // converter core
    input wire logic core_done,
    input wire logic [11:0] core_code,
    output logic core_start,
    output logic track,
    output logic [4:0] mux_sel,
    output logic temp_sel,
    output logic [1:0] input_mode,
    output logic power_up,
    output logic busy_pin,
    output logic conv_done,
    // analog output data
    output logic [11:0] dac_code
);
    typedef enum {ST_IDLE, ST_ACQ, ST_CONV, ST_PUSH} sac_state_type;

    sac_state_type state_reg, state_next;
    logic [15:0] ctrl_reg;
    logic [4:0] chan_reg;
    logic [31:0] result_reg;
    logic result_full_reg;
    logic [11:0] dac_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;
    logic sw_go_reg;
    logic pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic pla_d_reg;
    logic [5:0] div_cnt_reg;
    logic [4:0] acq_cnt_reg;
    logic [1:0] mode_cap_reg;
    logic [31:0] word_reg;
    logic core_start_reg, track_reg, busy_pin_reg, conv_done_reg;
    logic temp_sel_reg;

    // two-entry buffer between conversion and result register
    sac_stream_if #(.W(32)) cin_if ();
    sac_stream_if #(.W(32)) cout_if ();
    sac_buf2 #(.W(32), .DEPTH(2)) u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .in_s(cin_if.snk),
        .out_s(cout_if.src)
    );

    // control field decode
    wire [2:0] clk_code = ctrl_reg[SAC_CTRL_CLK_LSB +: 3];
    wire [1:0] acq_code = ctrl_reg[SAC_CTRL_ACQ_LSB +: 2];
    wire start_en = ctrl_reg[SAC_CTRL_START_EN];
    wire busy_en = ctrl_reg[SAC_CTRL_BUSY_EN];
    wire pwr_on = ctrl_reg[SAC_CTRL_POWER];
    wire [1:0] mode_sel = ctrl_reg[SAC_CTRL_MODE_LSB +: 2];
    wire [2:0] trig_sel = ctrl_reg[SAC_CTRL_TYPE_LSB +: 3];

    // apb decode
    wire setup = psel && !penable;
    wire acc = psel && penable && pready_reg;
    wire wr = acc && pwrite;
    wire [11:0] addr12 = 12'(paddr);
    wire hit_ctrl = (addr12 == SAC_OFS_CTRL);
    wire hit_chan = (addr12 == SAC_OFS_CHAN);
    wire hit_res = (addr12 == SAC_OFS_RESULT);
    wire hit_stat = (addr12 == SAC_OFS_STATUS);
    wire hit_dac = (addr12 == SAC_OFS_DAC);
    wire hit_any = hit_ctrl || hit_chan || hit_res || hit_stat || hit_dac;
    wire rd_res = acc && !pwrite && hit_res;

    // adc clock tick: divide by 1, 2, 4 .. 32
    wire [2:0] clk_sat = (clk_code > SAC_CLK_MAX) ? SAC_CLK_MAX : clk_code;
    wire [5:0] div_val = 6'h01 << clk_sat;
    wire tick = (div_cnt_reg == div_val - 6'h01);
    // acquisition length 2, 4, 8 or 16 adc clocks
    wire [4:0] acq_val = 5'h02 << acq_code;
    wire acq_end = tick && (acq_cnt_reg == acq_val - 5'h01);

    // trigger sources: pin falls, logic array rises, timer pulses
    wire pin_fall = pin_s3_reg && !pin_s2_reg;
    wire pla_rise = programmable_logic_array_trig && !pla_d_reg;
    wire hw_trig = (trig_sel == SAC_TRIG_PIN && pin_fall)
        || (trig_sel == SAC_TRIG_PLA && pla_rise)
        || (trig_sel == SAC_TRIG_TMR0 && timer0_ovf)
        || (trig_sel == SAC_TRIG_TMR1 && timer1_ovf);
    // new starts need start enable and power
    wire start_req = start_en && pwr_on && (sw_go_reg || hw_trig);
    // continuous mode keeps going without start enable
    wire cont_more = (trig_sel == SAC_TRIG_CONT) && pwr_on;
    wire is_sw_type = (pwdata[2:0] == SAC_TRIG_SINGLE) || (pwdata[2:0] == SAC_TRIG_CONT);

    // register write strobes
    wire wr_ctrl = wr && hit_ctrl;
    wire wr_chan = wr && hit_chan;
    wire wr_dac = wr && hit_dac;
    wire sw_go_set = wr_ctrl && pwdata[SAC_CTRL_START_EN] && is_sw_type;

    // result formatting
    wire diff_cap = (mode_cap_reg == SAC_MODE_DIFF);
    wire [11:0] res12 = diff_cap ? {~core_code[11], core_code[10:0]} : core_code;
    wire res_sign = diff_cap && res12[11];
    wire [31:0] fmt_word = {{4{res_sign}}, res12, 16'h0000};

    // buffer hookup
    assign cin_if.valid = (state_reg == ST_PUSH);
    assign cin_if.data = word_reg;
    assign cout_if.ready = !result_full_reg;
    wire res_load = cout_if.valid && !result_full_reg;

    // sequencer phase decode
    wire seq_idle = (state_reg == ST_IDLE);
    wire acq_enter = (state_next == ST_ACQ) && (state_reg != ST_ACQ);
    wire word_take = (state_reg == ST_CONV) && core_done;

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_req) state_next = ST_ACQ;
            end
            ST_ACQ: begin
                if (acq_end) state_next = ST_CONV;
            end
            ST_CONV: begin
                if (core_done) state_next = ST_PUSH;
            end
            ST_PUSH: begin
                if (cin_if.ready) state_next = cont_more ? ST_ACQ : ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // sequencer state and counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            div_cnt_reg <= '0;
            acq_cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            div_cnt_reg <= (tick || state_reg != ST_ACQ) ? 6'h00 : div_cnt_reg + 6'h01;
            if (state_reg != ST_ACQ) acq_cnt_reg <= '0;
            else if (tick) acq_cnt_reg <= acq_cnt_reg + 5'h01;
        end
    end

    // capture mode at start, result word on core done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_cap_reg <= SAC_MODE_SINGLE;
            word_reg <= '0;
        end else begin
            if (acq_enter) mode_cap_reg <= mode_sel;
            if (word_take) word_reg <= fmt_word;
        end
    end

    // core and pin strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_start_reg <= 1'b0;
            track_reg <= 1'b0;
            busy_pin_reg <= 1'b0;
        end else begin
            core_start_reg <= (state_reg == ST_ACQ) && acq_end;
            track_reg <= (state_next == ST_ACQ);
            busy_pin_reg <= busy_en && (state_next != ST_IDLE);
        end
    end

    // pin synchroniser and edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
            pin_s3_reg <= 1'b1;
            pla_d_reg <= 1'b0;
        end else begin
            pin_s1_reg <= external_conversion_start_pin_n;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pla_d_reg <= programmable_logic_array_trig;
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= SAC_CTRL_RST;
            chan_reg <= SAC_CHAN_RST;
            dac_reg <= SAC_DAC_RST;
            sw_go_reg <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_reg <= pwdata[15:0] & SAC_CTRL_MASK;
            if (wr_chan) chan_reg <= pwdata[4:0];
            if (wr_dac) dac_reg <= pwdata[SAC_RES_MSB:SAC_RES_LSB];
            // software go, held until a start request or the next control write clears it
            if (sw_go_set) sw_go_reg <= 1'b1;
            else if (start_req || wr_ctrl) sw_go_reg <= 1'b0;
        end
    end

    // result register and completion flag, load wins over read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= '0;
            result_full_reg <= 1'b0;
            conv_done_reg <= 1'b0;
        end else begin
            if (res_load) result_reg <= cout_if.data;
            if (res_load) result_full_reg <= 1'b1;
            else if (rd_res) result_full_reg <= 1'b0;
            conv_done_reg <= res_load;
        end
    end

    // temperature channel flag, loaded with the channel write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_sel_reg <= (SAC_CHAN_RST == SAC_CHAN_TEMP);
        end else if (wr_chan) begin
            temp_sel_reg <= (pwdata[4:0] == SAC_CHAN_TEMP);
        end
    end

    // status word: ready flag and sequencer activity
    wire conv_busy = !seq_idle;
    wire [31:0] stat_word = {30'h0, conv_busy, result_full_reg};

    // read data mux
    wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_reg}
        : hit_chan ? {27'h0, chan_reg}
        : hit_res ? result_reg
        : hit_stat ? stat_word
        : hit_dac ? {4'h0, dac_reg, 16'h0000}
        : 32'h0000_0000;

    // apb answer: data latched in setup, ready in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !hit_any;
            if (setup && !pwrite) prdata_reg <= rd_mux;
        end
    end

    // bus answer
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;

    // converter controls
    assign core_start = core_start_reg;
    assign track = track_reg;
    assign mux_sel = chan_reg;
    assign temp_sel = temp_sel_reg;
    assign input_mode = mode_sel;
    assign power_up = pwr_on;
    assign busy_pin = busy_pin_reg;
    assign conv_done = conv_done_reg;

    // analog output
    assign dac_code = dac_reg;
endmodule

/* File: sac_ctrl_asserts.sv */
`timescale 1ns/1ps
module sac_ctrl_asserts import sac_pkg::*; #(
    parameter int PAW = 12
) (
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [PAW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    // converter side
    input wire logic core_start,
    input wire logic track,
    input wire logic [4:0] mux_sel,
    input wire logic temp_sel,
    input wire logic power_up,
    input wire logic conv_done,
    input wire logic [11:0] dac_code
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a write access completing this cycle
    wire wr_acc = psel && penable && pwrite;
    // bus answers
    property p_ready_acc; psel && penable |-> pready; endproperty
    a_ready_acc: assert property (p_ready_acc) else $error("no pready in access cycle");
    property p_err_pair; pslverr |-> pready && psel && penable; endproperty
    a_err_pair: assert property (p_err_pair) else $error("pslverr outside access");
    // completion and acquisition timing
    property p_done_pulse; conv_done |=> !conv_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("conv_done longer than one cycle");
    property p_start_acq; core_start |-> $past(track); endproperty
    a_start_acq: assert property (p_start_acq) else $error("core_start without acquisition");
    property p_acq_min; $rose(track) |-> !core_start ##1 !core_start; endproperty
    a_acq_min: assert property (p_acq_min) else $error("acquisition too short");
    property p_power; $rose(track) |-> $past(power_up); endproperty
    a_power: assert property (p_power) else $error("conversion while powered down");
    // channel and output words follow register writes only
    property p_temp; temp_sel == (mux_sel == SAC_CHAN_TEMP); endproperty
    a_temp: assert property (p_temp) else $error("temp_sel disagrees with channel");
    property p_chan_wr; $changed(mux_sel) |-> $past(wr_acc && paddr == SAC_OFS_CHAN); endproperty
    a_chan_wr: assert property (p_chan_wr) else $error("channel changed without write");
    property p_dac_wr; $changed(dac_code) |-> $past(wr_acc && paddr == SAC_OFS_DAC); endproperty
    a_dac_wr: assert property (p_dac_wr) else $error("dac code changed without write");
    property p_pwr_wr; $changed(power_up) |-> $past(wr_acc && paddr == SAC_OFS_CTRL); endproperty
    a_pwr_wr: assert property (p_pwr_wr) else $error("power changed without write");
endmodule
bind sac_ctrl sac_ctrl_asserts #(.PAW(PAW)) i_sac_ctrl_asserts (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pready, .pslverr, .core_start, .track, .mux_sel, .temp_sel, .power_up, .conv_done, .dac_code);

/* File: sac_core_model.sv */
`timescale 1ns/1ps
module sac_core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // start from the sequencer, speed and code from the bench
    input wire logic core_start,
    input wire logic slow,
    input wire logic [11:0] code_in,
    // answer to the sequencer
    output logic core_done,
    output logic [11:0] core_code
);
    int cnt;
    // bit trials take 2 or 9 cycles; the code is only valid with done
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            core_done <= 1'b0;
            core_code <= 12'hA5A;
        end else begin
            core_done <= 1'b0;
            if (core_start) cnt <= slow ? 9 : 2;
            else if (cnt > 0) cnt <= cnt - 1;
            if (cnt == 1) begin
                core_done <= 1'b1;
                core_code <= code_in;
            end else core_code <= ~core_code; // stale code never looks valid
        end
    end
endmodule

/* File: sac_ctrl_tb.sv */
`timescale 1ns/1ps
module sac_ctrl_tb import sac_pkg::*; ();
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, pin_n = 1, programmable_logic_array = 0, t0 = 0, t1 = 0;
    logic slow = 0, pready, pslverr, core_done, core_start, track, temp_sel, power_up, busy_pin, conv_done;
    logic [11:0] paddr = 0, code_in = 0, core_code, dac_code;
    logic [31:0] pwdata = 0, prdata, rd, d, seed = 32'h3B1603C1;
    logic [4:0] mux_sel, ch;
    logic [1:0] input_mode, md = 0;
    logic [11:0] ra[4] = '{SAC_OFS_CTRL, SAC_OFS_CHAN, SAC_OFS_STATUS, SAC_OFS_DAC};
    logic [1:0] mt[4] = '{SAC_MODE_SINGLE, SAC_MODE_DIFF, SAC_MODE_PSEUDO, SAC_MODE_DIFF};
    logic [2:0] tt[4] = '{SAC_TRIG_PIN, SAC_TRIG_TMR0, SAC_TRIG_TMR1, SAC_TRIG_PLA};
    int mismatches = 0, cmp_count = 0, cyc = 0, ncore = 0, ndone = 0, trk = 0, trk_len = 0;
    logic [31:0] q[$];
    sac_ctrl i_sac_ctrl (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
        .external_conversion_start_pin_n(pin_n), .programmable_logic_array_trig(programmable_logic_array), .timer0_ovf(t0),
        .timer1_ovf(t1), .core_done, .core_code, .core_start, .track, .mux_sel, .temp_sel, .input_mode,
        .power_up, .busy_pin, .conv_done, .dac_code);
    sac_core_model i_sac_core_model (.pclk, .presetn, .core_start, .slow, .code_in, .core_done, .core_code);
    // clock
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected result word: offset code to twos complement in differential, sign on top
    function automatic logic [31:0] fmt(logic [1:0] m, logic [11:0] c);
        logic [11:0] t;
        t = (m == SAC_MODE_DIFF) ? {~c[11], c[10:0]} : c;
        return {{4{t[11] & (m == SAC_MODE_DIFF)}}, t, 16'h0};
    endfunction
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(logic w, logic [11:0] a, logic [31:0] v);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // wait for a ready result, read it and compare with the model queue
    task automatic res(string nm);
        int n = 0;
        do begin
            apb(0, SAC_OFS_STATUS, 0);
            n++;
        end while (!rd[SAC_STAT_READY] && n < 200);
        apb(0, SAC_OFS_RESULT, 0);
        chk(nm, q.size() ? q.pop_front() : 32'hDEAD0000, rd);
    endtask
    task automatic kick(logic [2:0] t);
        @(posedge pclk);
        pin_n <= (t != SAC_TRIG_PIN);
        t0 <= (t == SAC_TRIG_TMR0);
        t1 <= (t == SAC_TRIG_TMR1);
        programmable_logic_array <= (t == SAC_TRIG_PLA);
        @(posedge pclk);
        {t0, t1, programmable_logic_array} <= 3'h0;
        repeat (3) @(posedge pclk);
        pin_n <= 1;
    endtask
    // random core codes, expected words from the core's answers, run limit
    always @(posedge pclk) begin
        code_in <= 12'(rnd());
        if (core_done) begin
            q.push_back(fmt(md, core_code));
            ncore++;
        end
        if (conv_done) ndone++;
        // acquisition length: edges with track high, kept when it falls
        if (track) trk++;
        else if (trk > 0) begin
            trk_len = trk;
            trk = 0;
        end
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        foreach (ra[i]) begin
            apb(0, ra[i], 0);
            chk("reset value", (i == 0) ? {16'h0, SAC_CTRL_RST} : 32'h0, rd);
        end
        apb(1, SAC_OFS_CTRL, 32'hFFFFE000);
        apb(0, SAC_OFS_CTRL, 0);
        chk("ctrl reserved", 0, rd);
        apb(0, 12'hFFC, 0);
        chk("unmapped", 32'h1, {31'h0, er});
        d = rnd();
        apb(1, SAC_OFS_DAC, d);
        apb(0, SAC_OFS_DAC, 0);
        chk("dac word", d[27:16], rd[27:16]);
        chk("dac pin", d[27:16], dac_code);
        $display("test registers done");
        apb(1, SAC_OFS_CTRL, 32'h20);
        repeat (1000) @(posedge pclk);
        foreach (mt[i]) begin
            md = mt[i];
            ch = (i == 3) ? SAC_CHAN_TEMP : 5'(rnd() & 32'hF);
            slow <= i[0];
            apb(1, SAC_OFS_CHAN, {27'h0, ch});
            apb(1, SAC_OFS_CTRL, 32'hE4 | {27'h0, md, 3'h0});
            @(negedge pclk);
            chk("mux", ch, mux_sel);
            chk("temp", ch == SAC_CHAN_TEMP, temp_sel);
            chk("mode", md, input_mode);
            repeat (2) @(negedge pclk);
            chk("busy pin", 1, busy_pin);
            res("single result");
        end
        $display("test modes done");
        md = SAC_MODE_SINGLE;
        apb(1, SAC_OFS_CTRL, 32'h06A4);
        res("default timing result");
        chk("acq cycles", 16, trk_len);
        foreach (tt[i]) begin
            apb(1, SAC_OFS_CTRL, 32'hA0 | tt[i]);
            kick(tt[i]);
            res("trigger result");
        end
        $display("test triggers done");
        apb(1, SAC_OFS_CTRL, 32'h21);
        kick(SAC_TRIG_PIN);
        apb(1, SAC_OFS_CTRL, 32'hA2);
        kick(SAC_TRIG_PIN);
        apb(1, SAC_OFS_CTRL, 32'h84);
        repeat (40) @(posedge pclk);
        apb(0, SAC_OFS_STATUS, 0);
        chk("refused start", 0, rd[SAC_STAT_READY]);
        $display("test refusals done");
        apb(1, SAC_OFS_CTRL, 32'h20);
        repeat (1000) @(posedge pclk);
        slow <= 1;
        apb(1, SAC_OFS_CTRL, 32'hA5);
        repeat (300) @(posedge pclk);
        apb(1, SAC_OFS_CTRL, 32'h25);
        repeat (6) res("continuous result");
        apb(1, SAC_OFS_CTRL, 32'h20);
        repeat (100) @(posedge pclk);
        apb(0, SAC_OFS_STATUS, 0);
        while (rd[SAC_STAT_READY]) begin
            res("drained result");
            apb(0, SAC_OFS_STATUS, 0);
        end
        chk("lost words", 0, q.size());
        chk("done pulses", ncore, ndone);
        $display("test continuous done");
        test_done();
    end
endmodule
